// ### bench/mdio_master.sv
// Station-management controller model: makes MDC and MDIO frames.
// Assumes the bench resolves the shared data line with a pull-up.
`default_nettype none

module mdio_master (
  // Shared line
  input wire logic mdio_i,
  // Driven pins
  output logic mdc_o,
  output logic mdio_o,
  output logic mdio_oe_o
);
  timeunit 1ns;
  timeprecision 100ps;
  // Clock stands still low outside frames
  initial begin
    mdc_o = 1'h0;
    mdio_o = 1'h1;
    mdio_oe_o = 1'h0;
  end
  task automatic bit_out(input logic b);
    mdio_o = b;
    #62.5 mdc_o = 1'h1;
    #62.5 mdc_o = 1'h0;
  endtask
  task automatic frame(input logic wr, input logic [4:0] pa, ra, input logic [15:0] wd, output logic [15:0] rd);
    logic [45:0] hdr;
    hdr = {32'hFFFF_FFFF, 2'h1, wr ? 2'h1 : 2'h2, pa, ra};
    rd = 16'hFFFF;
    mdio_oe_o = 1'h1;
    for (int i = 45; i >= 0; i--) bit_out(hdr[i]);
    if (wr) begin
      bit_out(1'h1);
      bit_out(1'h0);
      for (int i = 15; i >= 0; i--) bit_out(wd[i]);
    end else begin
      mdio_oe_o = 1'h0;
      repeat (2) bit_out(1'h1);
      for (int i = 15; i >= 0; i--) begin
        #62.5 mdc_o = 1'h1;
        rd[i] = mdio_i;
        #62.5 mdc_o = 1'h0;
      end
    end
    mdio_oe_o = 1'h0;
    #1000;
  endtask
endmodule

`default_nettype wire

// ### bench/phy_mgmt_register_view_bench.sv
// Self-checking bench for the management register view.
// Assumes the design, checker and controller model are compiled first.
`default_nettype none

module phy_mgmt_register_view_bench;
  timeunit 1ns;
  timeprecision 100ps;
  logic mclk_i = 1'h0;
  logic rst_n_i = 1'h0;
  logic mdc_i, mdio_i, mdio_o, mdio_oe_o, m_d, m_oe;
  logic [4:0] soft_reset_busy_i = 5'h00, negotiation_finished_i = 5'h00;
  logic [4:0] far_end_fault_i = 5'h00, link_up_i = 5'h00;
  logic [24:0] partner_ability_i = 25'h000_0000;
  logic [4:0] mac_loopback_o, speed_100_o, autoneg_on_o, power_down_o, autoneg_rekick_o, full_duplex_o;
  logic [4:0] straight_wiring_force_o, crossover_auto_off_o, far_fault_off_o, transmit_off_o, indicator_off_o;
  logic [24:0] adv_ability_o;
  logic [15:0] r;
  logic [15:0] sh [5];
  int fails = 0;
  int total_checks = 0;
  int kicks = 0;
  int kicks0 = 0;
  always #5 mclk_i = ~mclk_i;
  // Released line floats up, so an unselected port reads all ones
  assign mdio_i = mdio_oe_o ? mdio_o : (m_oe ? m_d : 1'h1);
  always @(posedge mclk_i) if (|autoneg_rekick_o) kicks++;
  phy_mgmt_register_view u_phy_mgmt_register_view (.*);
  mdio_master u_mdio_master (.mdio_i(mdio_i), .mdc_o(mdc_i), .mdio_o(m_d), .mdio_oe_o(m_oe));
  ////////////////////////////////////////
  function automatic logic [15:0] out_word(input int p);
    return {1'h0, mac_loopback_o[p], speed_100_o[p], autoneg_on_o[p], power_down_o[p], 2'h0,
      full_duplex_o[p], 3'h0, straight_wiring_force_o[p], crossover_auto_off_o[p], far_fault_off_o[p],
      transmit_off_o[p], indicator_off_o[p]};
  endfunction
  function automatic logic [15:0] ctl_rd(input int p);
    return (sh[p] & 16'h3B1F) | {soft_reset_busy_i[p], 15'h0000};
  endfunction
  function automatic logic [15:0] stat_exp(input int p);
    return {1'h0, 4'hF, 4'h0, 1'h0, negotiation_finished_i[p], far_end_fault_i[p], 1'h1, link_up_i[p], 2'h0};
  endfunction
  task automatic check(input logic [15:0] seen, exp);
    total_checks++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic outs_ok;
    for (int q = 0; q < 5; q++) check(out_word(q), sh[q]);
  endtask
  task automatic wstep(input int p, input logic [15:0] d);
    int k0;
    k0 = kicks;
    u_mdio_master.frame(1'h1, 5'(p + 1), 5'h00, d, r);
    sh[p] = d & 16'h791F;
    check(16'(kicks - k0), {15'h0000, d[9]});
    outs_ok();
    u_mdio_master.frame(1'h0, 5'(p + 1), 5'h00, 16'h0000, r);
    check(r, ctl_rd(p));
  endtask
  task automatic adv_step(input logic [15:0] d);
    u_mdio_master.frame(1'h1, 5'h04, 5'h04, d, r);
    check(adv_ability_o[15:0], {d[5], 15'h7FFF});
    check({7'h00, adv_ability_o[24:16]}, {7'h00, 5'h1F, d[10], d[8:6]});
    u_mdio_master.frame(1'h0, 5'h04, 5'h04, 16'h0000, r);
    check(r, {5'h00, d[10], 1'h0, d[8:5], 5'h01});
    u_mdio_master.frame(1'h0, 5'h02, 5'h05, 16'h0000, r);
    check(r, {5'h00, partner_ability_i[9], 1'h0, partner_ability_i[8:5], 5'h00});
  endtask
  task automatic end_of_test;
    if (fails == 0 && total_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  ////////////////////////////////////////
  initial begin
    #900_000;
    fails++;
    end_of_test();
  end
  initial begin
    void'($urandom(41));
    repeat (16) @(posedge mclk_i);
    #1 rst_n_i = 1'h1;
    for (int p = 0; p < 5; p++) sh[p] = 16'h3000;
    repeat (10) @(posedge mclk_i);
    repeat (4) begin
      @(posedge mclk_i);
      #1 soft_reset_busy_i = 5'($urandom);
      negotiation_finished_i = 5'($urandom);
      far_end_fault_i = 5'($urandom);
      link_up_i = 5'($urandom);
      partner_ability_i = 25'($urandom);
      for (int p = 0; p < 5; p++) begin
        u_mdio_master.frame(1'h0, 5'(p + 1), 5'h01, 16'h0000, r);
        check(r, stat_exp(p));
      end
    end
    outs_ok();
    check(adv_ability_o[15:0], 16'hFFFF);
    check({7'h00, adv_ability_o[24:16]}, 16'h01FF);
    u_mdio_master.frame(1'h0, 5'h05, 5'h00, 16'h0000, r);
    check(r, ctl_rd(4));
    for (int k = 0; k < 16; k++) wstep(k % 5, 16'h0001 << k);
    wstep(2, 16'hFFFF);
    for (int i = 0; i < 8; i++) wstep($urandom_range(4), 16'($urandom));
    adv_step(16'($urandom));
    // Refused writes: status, unknown register, unknown port
    kicks0 = kicks;
    for (int i = 0; i < 4; i++) begin
      u_mdio_master.frame(1'h1, i[1] ? 5'h01 : 5'(i * 6), i[0] ? 5'h06 : 5'(i[1]), 16'hFFFF, r);
      outs_ok();
    end
    check(16'(kicks - kicks0), 16'h0000);
    u_mdio_master.frame(1'h0, 5'h02, 5'h07, 16'h0000, r);
    check(r, 16'h0000);
    u_mdio_master.frame(1'h0, 5'h00, 5'h00, 16'h0000, r);
    check(r, 16'hFFFF);
    u_mdio_master.frame(1'h0, 5'h06, 5'h01, 16'h0000, r);
    check(r, 16'hFFFF);
    end_of_test();
  end
endmodule

`default_nettype wire

// ### bench/phy_mgmt_register_view_chk.sv
// Port checker for the management register view.
// Assumes bind onto the top module, ports matched by name.
`default_nettype none

module phy_mgmt_register_view_chk (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_n_i,
  // Management data
  input wire logic mdio_o,
  input wire logic mdio_oe_o,
  // Port controls
  input wire logic [4:0] mac_loopback_o,
  input wire logic [4:0] speed_100_o,
  input wire logic [4:0] autoneg_on_o,
  input wire logic [4:0] power_down_o,
  input wire logic [4:0] autoneg_rekick_o,
  input wire logic [4:0] full_duplex_o,
  input wire logic [4:0] straight_wiring_force_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);
  ////////////////////////////////////////
  reset_vals_a: assert property ($rose(rst_n_i) |-> speed_100_o == 5'h1F &&
    autoneg_on_o == 5'h1F && power_down_o == 5'h00 && full_duplex_o == 5'h00 && mac_loopback_o == 5'h00)
    else $error("control outputs left reset wrong");
  rekick_pulse_a: assert property (|autoneg_rekick_o |->
    $onehot(autoneg_rekick_o) ##1 autoneg_rekick_o == 5'h00) else $error("restart pulse too long");
  one_port_a: assert property ($changed(speed_100_o) |->
    $onehot(speed_100_o ^ $past(speed_100_o))) else $error("speed changed on several ports");
  pdn_single_a: assert property ($changed(power_down_o) |->
    $countones(power_down_o ^ $past(power_down_o)) == 1) else $error("power down hit several ports");
  quiet_read_a: assert property (mdio_oe_o |-> $stable(full_duplex_o) &&
    $stable(straight_wiring_force_o) && $stable(mac_loopback_o)) else $error("control moved in a read");
  ta_zero_a: assert property ($rose(mdio_oe_o) |-> !mdio_o) else $error("turnaround not zero");
  read_len_a: assert property ($rose(mdio_oe_o) |-> ##[208:217] $fell(mdio_oe_o))
    else $error("read drive length wrong");
  idle_high_a: assert property (!mdio_oe_o |-> mdio_o) else $error("data low while released");
endmodule

bind phy_mgmt_register_view phy_mgmt_register_view_chk u_chk (.*);

`default_nettype wire

// ### design/mgmt_pin_sync.sv
// Three-stage synchroniser with agreement filter for one pin.
// Assumes the pin is asynchronous to clk_i.
`default_nettype none

module mgmt_pin_sync #(
  parameter logic RESET_VAL = 1'b0
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Pin and result
  input wire logic pin_i,
  output logic level_o
);

  logic s1;
  logic s2;
  logic s3;

  // First stage feeds only the second
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s1 <= RESET_VAL;
      s2 <= RESET_VAL;
      s3 <= RESET_VAL;
    end else begin
      s1 <= pin_i;
      s2 <= s1;
      s3 <= s2;
    end
  end

  // A change counts once two later stages agree
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      level_o <= RESET_VAL;
    end else if (s2 == s3) begin
      level_o <= s3;
    end
  end

endmodule

`default_nettype wire

// ### design/phy_mgmt_cfg.svh
// Constants of the per-port station-management register view.
// Assumes inclusion by bare name from the register view design module.
`ifndef PHY_MGMT_CFG_SVH
`define PHY_MGMT_CFG_SVH

// Frame layout
`define PMV_PRE_ONES 6'h20
`define PMV_HDR_LAST 5'h0C
`define PMV_WR_LAST 5'h11
`define PMV_RD_LAST 5'h10
`define PMV_OP_RD 2'h2
`define PMV_OP_WR 2'h1

// Port addressing
`define PMV_PHYAD_FIRST 5'h01
`define PMV_PHYAD_LAST 5'h05

// Register addresses
`define PMV_REG_CTL 5'h00
`define PMV_REG_STAT 5'h01
`define PMV_REG_ID_HI 5'h02
`define PMV_REG_ID_LO 5'h03
`define PMV_REG_ADV 5'h04
`define PMV_REG_LPA 5'h05

// Control field positions
`define PMV_CTL_SRST 15
`define PMV_CTL_LOOP 14
`define PMV_CTL_SPD 13
`define PMV_CTL_ANEN 12
`define PMV_CTL_PDN 11
`define PMV_CTL_REKICK 9
`define PMV_CTL_DUP 8
`define PMV_CTL_MDI 4
`define PMV_CTL_XOFF 3
`define PMV_CTL_FEF 2
`define PMV_CTL_TXOFF 1
`define PMV_CTL_LED 0

// Reset values
`define PMV_RST_LOOP 1'h0
`define PMV_RST_SPD 1'h1
`define PMV_RST_ANEN 1'h1
`define PMV_RST_PDN 1'h0
`define PMV_RST_DUP 1'h0
`define PMV_RST_OFF 1'h0
`define PMV_RST_ADV 5'h1F

// Status and advertisement constants
`define PMV_STAT_T4 1'h0
`define PMV_STAT_CAPS 4'hF
`define PMV_STAT_ANCAP 1'h1
`define PMV_ADV_SEL 5'h01

// Identity words, arbitrary neutral values
`define PMV_ID_HI 16'h5A5A
`define PMV_ID_LO 16'h0C30

`endif

// ### design/phy_mgmt_pkg.sv
// Types shared by the register view.
// Assumes the cfg header sits next to it.
`default_nettype none

package phy_mgmt_pkg;
  typedef enum logic [2:0] {
    ST_PRE,
    ST_HDR,
    ST_TA_RD,
    ST_RD,
    ST_WR
  } mgmt_state_e;

  typedef logic [4:0] port_vec_t;
  typedef logic [2:0] port_idx_t;
endpackage

`default_nettype wire

// ### design/phy_mgmt_register_view.sv
// Station-management slave for five switch ports, control and status view.
// Assumes MDC and MDIO arrive asynchronously; MDC well below mclk_i / 8.
`include "phy_mgmt_cfg.svh"
`default_nettype none

// Summary of operation
// - Port N answers at management address N + 1.
// - Only register addresses zero to five exist.
// - Control bit 15 shows soft reset, read-only.
// - Control bit 14 write-only MAC loopback.
// - Control bit 13 selects 100 or 10.
// - Control bit 12 enables auto-negotiation, default one.
// - Control bit 11 powers the transceiver down.
// - Control bit 9 restarts auto-negotiation.
// - Control bit 8 forces full duplex.
// - Control bit 4 forces straight MDI wiring.
// - Control bit 3 disables automatic crossover.
// - Control bit 2 disables far-end fault detection.
// - Control bit 1 disables transmission.
// - Control bit 0 switches port indicators off.
// - Status bit 15 always reads zero.
// - Status bits 14 to 11 read one.
// - Status bit 5 shows negotiation finished.
// - Status bit 4 shows far-end fault.
// - Status bit 3 reads one, negotiation capable.
module phy_mgmt_register_view
  import phy_mgmt_pkg::*;
(
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_n_i,
  // Management link
  input wire logic mdc_i,
  input wire logic mdio_i,
  output logic mdio_o,
  output logic mdio_oe_o,
  // Port status from the transceivers
  input wire logic [4:0] soft_reset_busy_i,
  input wire logic [4:0] negotiation_finished_i,
  input wire logic [4:0] far_end_fault_i,
  input wire logic [4:0] link_up_i,
  input wire logic [24:0] partner_ability_i,
  // Port controls to the transceivers
  output logic [4:0] mac_loopback_o,
  output logic [4:0] speed_100_o,
  output logic [4:0] autoneg_on_o,
  output logic [4:0] power_down_o,
  output logic [4:0] autoneg_rekick_o,
  output logic [4:0] full_duplex_o,
  output logic [4:0] straight_wiring_force_o,
  output logic [4:0] crossover_auto_off_o,
  output logic [4:0] far_fault_off_o,
  output logic [4:0] transmit_off_o,
  output logic [4:0] indicator_off_o,
  output logic [24:0] adv_ability_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Decoding helpers

  function automatic logic port_hit(input logic [4:0] phyad);
    port_hit = (phyad >= `PMV_PHYAD_FIRST) && (phyad <= `PMV_PHYAD_LAST);
  endfunction

  function automatic port_idx_t port_index(input logic [4:0] phyad);
    logic [4:0] diff;
    diff = phyad - `PMV_PHYAD_FIRST;
    port_index = diff[2:0];
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Pin sampling

  logic mdc_f;
  logic mdio_f;
  logic mdc_prev;

  mgmt_pin_sync #(
    .RESET_VAL(1'b0)
  ) u_mdc_sync (
    .clk_i(mclk_i),
    .rst_n_i(rst_n_i),
    .pin_i(mdc_i),
    .level_o(mdc_f)
  );

  // MDIO idles high through its pull-up
  mgmt_pin_sync #(
    .RESET_VAL(1'b1)
  ) u_mdio_sync (
    .clk_i(mclk_i),
    .rst_n_i(rst_n_i),
    .pin_i(mdio_i),
    .level_o(mdio_f)
  );

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mdc_prev <= 1'b0;
    end else begin
      mdc_prev <= mdc_f;
    end
  end

  // Edges come from the filtered level, so one noisy sample cannot clock a bit
  wire mdc_rise = mdc_f & ~mdc_prev;

  ////////////////////////////////////////////////////////////////////////////
  // Frame decoding

  mgmt_state_e state;
  logic [5:0] pre_cnt;
  logic [4:0] bit_cnt;
  logic [12:0] hdr_sr;
  logic [17:0] wr_sr;
  logic [15:0] rd_sr;
  logic wr_stb;
  logic [4:0] wr_phyad;
  logic [4:0] wr_regad;
  logic [15:0] wr_data;

  wire [12:0] hdr_next = {hdr_sr[11:0], mdio_f};
  wire [17:0] wr_next = {wr_sr[16:0], mdio_f};
  wire hdr_st_ok = hdr_next[12];
  wire [1:0] hdr_op = hdr_next[11:10];
  wire [4:0] hdr_phyad = hdr_next[9:5];
  wire [4:0] hdr_regad = hdr_next[4:0];
  wire hdr_mine = hdr_st_ok & port_hit(hdr_phyad);
  wire hdr_rd = hdr_mine & (hdr_op == `PMV_OP_RD);
  wire hdr_wr = hdr_mine & (hdr_op == `PMV_OP_WR);
  wire pre_full = (pre_cnt == `PMV_PRE_ONES);

  ////////////////////////////////////////////////////////////////////////////
  // Read word selection

  // Unknown ports fold onto index zero; their word is never driven out
  wire rd_port_ok = port_hit(hdr_phyad);
  wire port_idx_t rd_idx = rd_port_ok ? port_index(hdr_phyad) : 3'h0;

  wire [15:0] ctl_word = {
    soft_reset_busy_i[rd_idx],
    1'b0,
    speed_100_o[rd_idx],
    autoneg_on_o[rd_idx],
    power_down_o[rd_idx],
    1'b0,
    autoneg_rekick_o[rd_idx],
    full_duplex_o[rd_idx],
    3'h0,
    straight_wiring_force_o[rd_idx],
    crossover_auto_off_o[rd_idx],
    far_fault_off_o[rd_idx],
    transmit_off_o[rd_idx],
    indicator_off_o[rd_idx]
  };

  wire [15:0] stat_word = {
    `PMV_STAT_T4,
    `PMV_STAT_CAPS,
    5'h00,
    negotiation_finished_i[rd_idx],
    far_end_fault_i[rd_idx],
    `PMV_STAT_ANCAP,
    link_up_i[rd_idx],
    2'h0
  };

  wire [4:0] adv_sel = adv_ability_o[rd_idx * 5 +: 5];
  wire [4:0] lpa_sel = partner_ability_i[rd_idx * 5 +: 5];
  wire [15:0] adv_word = {5'h00, adv_sel[4], 1'b0, adv_sel[3:0], `PMV_ADV_SEL};
  wire [15:0] lpa_word = {5'h00, lpa_sel[4], 1'b0, lpa_sel[3:0], 5'h00};

  // Registers two, three and five are read-only views
  wire [15:0] rd_word =
    (hdr_regad == `PMV_REG_CTL) ? ctl_word :
    (hdr_regad == `PMV_REG_STAT) ? stat_word :
    (hdr_regad == `PMV_REG_ID_HI) ? `PMV_ID_HI :
    (hdr_regad == `PMV_REG_ID_LO) ? `PMV_ID_LO :
    (hdr_regad == `PMV_REG_ADV) ? adv_word :
    (hdr_regad == `PMV_REG_LPA) ? lpa_word :
    16'h0000;

  ////////////////////////////////////////////////////////////////////////////
  // Frame state machine
  // Bits are taken on MDC rise; read data change on the rise too,
  // giving the controller a full MDC period before its next sample.
  // Limitation: a frame cut short resumes on the next frame's preamble bits.

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state <= ST_PRE;
      pre_cnt <= 6'h00;
      bit_cnt <= 5'h00;
      hdr_sr <= 13'h0000;
      wr_sr <= 18'h0_0000;
      rd_sr <= 16'h0000;
      mdio_o <= 1'b1;
      mdio_oe_o <= 1'b0;
      wr_stb <= 1'b0;
      wr_phyad <= 5'h00;
      wr_regad <= 5'h00;
      wr_data <= 16'h0000;
    end else begin
      wr_stb <= 1'b0;
      if (mdc_rise) begin
        case (state)
          ST_PRE: begin
            if (mdio_f) begin
              if (!pre_full) begin
                pre_cnt <= pre_cnt + 6'h01;
              end
            end else begin
              pre_cnt <= 6'h00;
              if (pre_full) begin
                state <= ST_HDR;
                bit_cnt <= 5'h00;
              end
            end
          end
          ST_HDR: begin
            hdr_sr <= hdr_next;
            bit_cnt <= bit_cnt + 5'h01;
            if (bit_cnt == `PMV_HDR_LAST) begin
              bit_cnt <= 5'h00;
              wr_phyad <= hdr_phyad;
              wr_regad <= hdr_regad;
              rd_sr <= rd_word;
              if (hdr_rd) begin
                state <= ST_TA_RD;
              end else if (hdr_wr) begin
                state <= ST_WR;
              end else begin
                state <= ST_PRE;
              end
            end
          end
          ST_TA_RD: begin
            mdio_oe_o <= 1'b1;
            mdio_o <= 1'b0;
            state <= ST_RD;
          end
          ST_RD: begin
            bit_cnt <= bit_cnt + 5'h01;
            if (bit_cnt == `PMV_RD_LAST) begin
              mdio_oe_o <= 1'b0;
              mdio_o <= 1'b1;
              state <= ST_PRE;
            end else begin
              mdio_o <= rd_sr[15];
              rd_sr <= {rd_sr[14:0], 1'b0};
            end
          end
          ST_WR: begin
            wr_sr <= wr_next;
            bit_cnt <= bit_cnt + 5'h01;
            if (bit_cnt == `PMV_WR_LAST) begin
              wr_stb <= 1'b1;
              wr_data <= wr_next[15:0];
              state <= ST_PRE;
            end
          end
          default: begin
            state <= ST_PRE;
            mdio_oe_o <= 1'b0;
            mdio_o <= 1'b1;
            pre_cnt <= 6'h00;
            bit_cnt <= 5'h00;
          end
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register writes

  // Only registers zero and four hold state; other writes fall through
  wire port_idx_t wr_idx = port_index(wr_phyad);
  wire wr_ok = wr_stb & port_hit(wr_phyad);
  wire wr_ctl = wr_ok & (wr_regad == `PMV_REG_CTL);
  wire wr_adv = wr_ok & (wr_regad == `PMV_REG_ADV);

  genvar p;
  generate
    for (p = 0; p < 5; p++) begin : g_port
      wire ctl_hit = wr_ctl & (wr_idx == port_idx_t'(p));
      wire adv_hit = wr_adv & (wr_idx == port_idx_t'(p));

      // Restart is a one-cycle pulse, so it never stays set
      always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
          autoneg_rekick_o[p] <= 1'b0;
        end else begin
          autoneg_rekick_o[p] <= ctl_hit & wr_data[`PMV_CTL_REKICK];
        end
      end

      always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
          mac_loopback_o[p] <= `PMV_RST_LOOP;
          speed_100_o[p] <= `PMV_RST_SPD;
          autoneg_on_o[p] <= `PMV_RST_ANEN;
          power_down_o[p] <= `PMV_RST_PDN;
          full_duplex_o[p] <= `PMV_RST_DUP;
          straight_wiring_force_o[p] <= `PMV_RST_OFF;
          crossover_auto_off_o[p] <= `PMV_RST_OFF;
          far_fault_off_o[p] <= `PMV_RST_OFF;
          transmit_off_o[p] <= `PMV_RST_OFF;
          indicator_off_o[p] <= `PMV_RST_OFF;
        end else if (ctl_hit) begin
          mac_loopback_o[p] <= wr_data[`PMV_CTL_LOOP];
          speed_100_o[p] <= wr_data[`PMV_CTL_SPD];
          autoneg_on_o[p] <= wr_data[`PMV_CTL_ANEN];
          power_down_o[p] <= wr_data[`PMV_CTL_PDN];
          full_duplex_o[p] <= wr_data[`PMV_CTL_DUP];
          straight_wiring_force_o[p] <= wr_data[`PMV_CTL_MDI];
          crossover_auto_off_o[p] <= wr_data[`PMV_CTL_XOFF];
          far_fault_off_o[p] <= wr_data[`PMV_CTL_FEF];
          transmit_off_o[p] <= wr_data[`PMV_CTL_TXOFF];
          indicator_off_o[p] <= wr_data[`PMV_CTL_LED];
        end
      end

      // Advertised abilities: pause, 100 full, 100 half, 10 full, 10 half
      always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
          adv_ability_o[p * 5 +: 5] <= `PMV_RST_ADV;
        end else if (adv_hit) begin
          adv_ability_o[p * 5 +: 5] <= {wr_data[10], wr_data[8:5]};
        end
      end
    end
  endgenerate

endmodule

`default_nettype wire
